/* File: design/drl_refresh.sv */
// Display refresh data path: rotated fetch, palette look-up, 5-6-5 bypass and inversion.
//
// Functional notes
// - Palette-indexed monochrome depths output only the table's green channel.
// - 16 bpp monochrome bypasses the table and outputs the green field.
// - 16 bpp color bypasses the table and outputs red, green, blue directly.
// - A 16 bpp pixel word packs red 5, green 6, blue 5 bits.
// - Bytes are little endian; lower addresses hold earlier pixels.
// - Video inversion is applied after the look-up table stage.
// - The image may be rotated 90, 180 or 270 degrees counter-clockwise.
// - Host buffer accesses are untranslated; rotation acts only on refresh fetches.
// - Pixel doubling is disabled whenever 90 or 270 degree rotation is selected.
// - Rotation select bits 17:16: 01 is 90, 10 is 180, 11 is 270.
// - Refresh starts at the 17-bit start word address and follows rotation order.
// - 90 degree refresh visits quadrants B, D, A, C.
// - 180 degree refresh visits D, C, B, A from the last stored pixel.
// - 270 degree refresh visits quadrants C, A, D, B.
// - The 10-bit line offset holds the line width in 32-bit words.
//
// Our own choices: the APB register port and the register offsets.
module drl_refresh
    import drl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic [16:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [7:0] pix_red_q,
    output logic [7:0] pix_green_q,
    output logic [7:0] pix_blue_q,
    output logic pix_first_q,
    output logic pix_eol_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [2:0] bpp_q;
    logic color_q;
    logic invert_q;
    logic double_q;
    drl_rot_t rot_q;
    logic enable_q;
    logic [DRL_START_W-1:0] start_q;
    logic [DRL_LOFS_W-1:0] lofs_q;
    logic [DRL_DIM_W-1:0] width_q;
    logic [DRL_DIM_W-1:0] height_q;
    logic [7:0] lut_idx_q;

    // Refresh state.
    drl_state_t state_q;
    logic [DRL_DIM_W-1:0] x_q;
    logic [DRL_DIM_W-1:0] y_q;
    logic [DRL_BITADDR_W-1:0] cur_q;
    logic [DRL_BITADDR_W-1:0] line_q;
    logic [15:0] pixel_q;
    logic second_q;

    logic wr_acc;
    logic rd_acc;
    logic addr_hit;
    logic lut_wr;
    logic [5:0] bits;
    logic [DRL_BITADDR_W-1:0] pix_step;
    logic [DRL_BITADDR_W-1:0] line_step;
    logic [DRL_BITADDR_W-1:0] frame_base;
    logic [DRL_BITADDR_W-1:0] off_bits;
    logic [DRL_BITADDR_W-1:0] bpp_ext;
    logic dbl_allowed;
    logic last_x;
    logic last_y;
    logic [23:0] lut_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Picks the pixel at bit position pos of a fetched word. Byte lanes are little
    // endian and, inside a byte, the earliest pixel sits in the most significant bits.
    function automatic logic [15:0] pick_pixel(input logic [31:0] word, input logic [4:0] pos,
                                               input logic [5:0] nbits);
        logic [7:0] byte_v;
        logic [3:0] shift;
        logic [7:0] mask;
        logic [15:0] r;
        byte_v = word[{pos[4:3], 3'b000} +: 8];
        shift = 4'd8 - {1'b0, pos[2:0]} - nbits[3:0];
        mask = 8'hff >> (4'd8 - nbits[3:0]);
        r = 16'h0000;
        if (nbits == 6'h10)
        begin
            r = pos[4] ? word[31:16] : word[15:0];
        end
        else
        begin
            r = {8'h00, (byte_v >> shift) & mask};
        end
        return r;
    endfunction : pick_pixel

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave. Every access completes in its first access cycle.
    assign wr_acc = psel && penable && pwrite && ce;
    assign rd_acc = psel && !pwrite;
    assign pready = 1'b1;
    assign lut_wr = wr_acc && (paddr == DRL_OFS_LUT_DATA);

    always_comb
    begin
        unique case (paddr)
            DRL_OFS_CTRL, DRL_OFS_START, DRL_OFS_LOFS, DRL_OFS_PANEL, DRL_OFS_STATUS,
            DRL_OFS_LUT_IDX, DRL_OFS_LUT_DATA: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_hit;

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_acc)
        begin
            unique case (paddr)
                DRL_OFS_CTRL:
                begin
                    prdata[DRL_CTRL_BPP_LSB +: 3] = bpp_q;
                    prdata[DRL_CTRL_COLOR_BIT] = color_q;
                    prdata[DRL_CTRL_INVERT_BIT] = invert_q;
                    prdata[DRL_CTRL_DOUBLE_BIT] = double_q;
                    prdata[DRL_CTRL_ROT_LSB +: 2] = rot_q;
                    prdata[DRL_CTRL_ENABLE_BIT] = enable_q;
                end
                DRL_OFS_START: prdata[DRL_START_W-1:0] = start_q;
                DRL_OFS_LOFS: prdata[DRL_LOFS_W-1:0] = lofs_q;
                DRL_OFS_PANEL:
                begin
                    prdata[DRL_PANEL_W_LSB +: DRL_DIM_W] = width_q;
                    prdata[DRL_PANEL_H_LSB +: DRL_DIM_W] = height_q;
                end
                DRL_OFS_STATUS:
                begin
                    prdata[DRL_STAT_BUSY_BIT] = (state_q != DRL_ST_IDLE);
                    prdata[DRL_STAT_LINE_LSB +: DRL_DIM_W] = y_q;
                end
                DRL_OFS_LUT_IDX: prdata[7:0] = lut_idx_q;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // Mode control. New values steer the refresh from the next clock on, even mid-pixel, so software
    // should clear the enable bit before changing depth or rotation mid-frame.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bpp_q <= DRL_CTRL_RST[DRL_CTRL_BPP_LSB +: 3];
            color_q <= DRL_CTRL_RST[DRL_CTRL_COLOR_BIT];
            invert_q <= DRL_CTRL_RST[DRL_CTRL_INVERT_BIT];
            double_q <= DRL_CTRL_RST[DRL_CTRL_DOUBLE_BIT];
            rot_q <= drl_rot_t'(DRL_CTRL_RST[DRL_CTRL_ROT_LSB +: 2]);
            enable_q <= DRL_CTRL_RST[DRL_CTRL_ENABLE_BIT];
        end
        else if (wr_acc && paddr == DRL_OFS_CTRL)
        begin
            bpp_q <= pwdata[DRL_CTRL_BPP_LSB +: 3];
            color_q <= pwdata[DRL_CTRL_COLOR_BIT];
            invert_q <= pwdata[DRL_CTRL_INVERT_BIT];
            double_q <= pwdata[DRL_CTRL_DOUBLE_BIT];
            rot_q <= drl_rot_t'(pwdata[DRL_CTRL_ROT_LSB +: 2]);
            enable_q <= pwdata[DRL_CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_q <= DRL_START_RST;
            lofs_q <= DRL_LOFS_RST;
        end
        else if (wr_acc && paddr == DRL_OFS_START)
        begin
            start_q <= pwdata[DRL_START_W-1:0];
        end
        else if (wr_acc && paddr == DRL_OFS_LOFS)
        begin
            lofs_q <= pwdata[DRL_LOFS_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            width_q <= DRL_DIM_RST;
            height_q <= DRL_DIM_RST;
        end
        else if (wr_acc && paddr == DRL_OFS_PANEL)
        begin
            width_q <= pwdata[DRL_PANEL_W_LSB +: DRL_DIM_W];
            height_q <= pwdata[DRL_PANEL_H_LSB +: DRL_DIM_W];
        end
    end

    // Palette loading auto-increments the index so a full table is one burst of writes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lut_idx_q <= 8'h00;
        end
        else if (wr_acc && paddr == DRL_OFS_LUT_IDX)
        begin
            lut_idx_q <= pwdata[7:0];
        end
        else if (lut_wr)
        begin
            lut_idx_q <= lut_idx_q + 8'h01;
        end
    end

    drl_lut_mem u_lut
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .wr_en(lut_wr),
        .wr_idx(lut_idx_q),
        .wr_data(pwdata[DRL_LUT_W-1:0]),
        .rd_en(state_q == DRL_ST_LOOK),
        .rd_idx(pixel_q[7:0]),
        .rd_data_q(lut_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Rotation walk. Positions are bit addresses into the buffer, so the same stepping
    // serves every depth. Host accesses never pass through here and stay untranslated.
    assign bits = drl_bpp_bits(bpp_q);
    assign off_bits = {{(DRL_BITADDR_W-DRL_LOFS_W-5){1'b0}}, lofs_q, 5'b00000};
    assign bpp_ext = {{(DRL_BITADDR_W-6){1'b0}}, bits};

    always_comb
    begin
        frame_base = {start_q, 5'b00000};
        pix_step = bpp_ext;
        line_step = off_bits;
        unique case (rot_q)
            DRL_ROT_0:
            begin
                pix_step = bpp_ext;
                line_step = off_bits;
            end
            DRL_ROT_90:
            begin
                frame_base = {start_q, 5'b00000} + DRL_BITADDR_W'(6'd32 - bits);
                pix_step = off_bits;
                line_step = DRL_BITADDR_W'(0) - bpp_ext;
            end
            DRL_ROT_180:
            begin
                frame_base = {start_q, 5'b00000} + DRL_BITADDR_W'(6'd32 - bits);
                pix_step = DRL_BITADDR_W'(0) - bpp_ext;
                line_step = DRL_BITADDR_W'(0) - off_bits;
            end
            DRL_ROT_270:
            begin
                pix_step = DRL_BITADDR_W'(0) - off_bits;
                line_step = bpp_ext;
            end
        endcase
    end

    // Quarter turns fetch one word per pixel across lines, so pixel doubling is only
    // allowed at 0 and 180 degrees.
    assign dbl_allowed = double_q && (rot_q == DRL_ROT_0 || rot_q == DRL_ROT_180);
    assign last_x = (x_q == width_q - 10'h001);
    assign last_y = (y_q == height_q - 10'h001);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= DRL_ST_IDLE;
        end
        else if (ce)
        begin
            unique case (state_q)
                DRL_ST_IDLE: state_q <= enable_q ? DRL_ST_FETCH : DRL_ST_IDLE;
                DRL_ST_FETCH: state_q <= mem_ack ? DRL_ST_LOOK : DRL_ST_FETCH;
                DRL_ST_LOOK: state_q <= DRL_ST_FORM;
                DRL_ST_FORM: state_q <= DRL_ST_SEND;
                DRL_ST_SEND:
                begin
                    if (pix_ready && !(dbl_allowed && !second_q))
                    begin
                        state_q <= enable_q ? DRL_ST_FETCH : DRL_ST_IDLE;
                    end
                end
                default: state_q <= DRL_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            x_q <= '0;
            y_q <= '0;
            cur_q <= '0;
            line_q <= '0;
            second_q <= 1'b0;
        end
        else if (ce)
        begin
            if (state_q == DRL_ST_IDLE)
            begin
                x_q <= '0;
                y_q <= '0;
                cur_q <= frame_base;
                line_q <= frame_base;
                second_q <= 1'b0;
            end
            else if (state_q == DRL_ST_SEND && pix_ready)
            begin
                if (dbl_allowed && !second_q)
                begin
                    second_q <= 1'b1;
                end
                else
                begin
                    second_q <= 1'b0;
                    if (!last_x)
                    begin
                        x_q <= x_q + 10'h001;
                        cur_q <= cur_q + pix_step;
                    end
                    else if (!last_y)
                    begin
                        x_q <= '0;
                        y_q <= y_q + 10'h001;
                        line_q <= line_q + line_step;
                        cur_q <= line_q + line_step;
                    end
                    else
                    begin
                        x_q <= '0;
                        y_q <= '0;
                        line_q <= frame_base;
                        cur_q <= frame_base;
                    end
                end
            end
        end
    end

    assign mem_req = (state_q == DRL_ST_FETCH);
    assign mem_addr = cur_q[DRL_BITADDR_W-1:5];
    assign pix_valid = (state_q == DRL_ST_SEND);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pixel_q <= 16'h0000;
        end
        else if (ce && state_q == DRL_ST_FETCH && mem_ack)
        begin
            pixel_q <= pick_pixel(mem_rdata, cur_q[4:0], bits);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output forming. 5-6-5 fields are left aligned in the 8-bit channels.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pix_red_q <= 8'h00;
            pix_green_q <= 8'h00;
            pix_blue_q <= 8'h00;
            pix_first_q <= 1'b0;
            pix_eol_q <= 1'b0;
        end
        else if (ce && state_q == DRL_ST_FORM)
        begin
            logic [7:0] r;
            logic [7:0] g;
            logic [7:0] b;
            r = 8'h00;
            g = 8'h00;
            b = 8'h00;
            if (bits == 6'h10)
            begin
                r = {pixel_q[15:11], 3'b000};
                g = {pixel_q[10:5], 2'b00};
                b = {pixel_q[4:0], 3'b000};
                if (!color_q)
                begin
                    r = g;
                    b = g;
                end
            end
            else
            begin
                r = lut_data[DRL_LUT_RED_LSB +: 8];
                g = lut_data[DRL_LUT_GREEN_LSB +: 8];
                b = lut_data[DRL_LUT_BLUE_LSB +: 8];
                if (!color_q)
                begin
                    r = g;
                    b = g;
                end
            end
            pix_red_q <= invert_q ? ~r : r;
            pix_green_q <= invert_q ? ~g : g;
            pix_blue_q <= invert_q ? ~b : b;
            pix_first_q <= (x_q == '0) && (y_q == '0);
            pix_eol_q <= last_x;
        end
    end

endmodule : drl_refresh

/* File: design/drl_pkg.sv */
// Shared constants, register map and helper functions of the display refresh path.
package drl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the APB bus.
    localparam logic [7:0] DRL_OFS_CTRL = 8'h10;
    localparam logic [7:0] DRL_OFS_START = 8'h40;
    localparam logic [7:0] DRL_OFS_LOFS = 8'h44;
    localparam logic [7:0] DRL_OFS_PANEL = 8'h48;
    localparam logic [7:0] DRL_OFS_STATUS = 8'h4c;
    localparam logic [7:0] DRL_OFS_LUT_IDX = 8'h80;
    localparam logic [7:0] DRL_OFS_LUT_DATA = 8'h84;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int DRL_CTRL_BPP_LSB = 0;
    localparam int DRL_CTRL_COLOR_BIT = 4;
    localparam int DRL_CTRL_INVERT_BIT = 5;
    localparam int DRL_CTRL_DOUBLE_BIT = 6;
    localparam int DRL_CTRL_ROT_LSB = 16;
    localparam int DRL_CTRL_ENABLE_BIT = 24;
    localparam int DRL_PANEL_W_LSB = 0;
    localparam int DRL_PANEL_H_LSB = 16;
    localparam int DRL_STAT_BUSY_BIT = 0;
    localparam int DRL_STAT_LINE_LSB = 16;
    localparam int DRL_LUT_RED_LSB = 16;
    localparam int DRL_LUT_GREEN_LSB = 8;
    localparam int DRL_LUT_BLUE_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and reset values.
    localparam int DRL_START_W = 17;
    localparam int DRL_LOFS_W = 10;
    localparam int DRL_DIM_W = 10;
    localparam int DRL_BITADDR_W = 22;
    localparam int DRL_LUT_DEPTH = 256;
    localparam int DRL_LUT_W = 24;
    localparam logic [31:0] DRL_CTRL_RST = 32'h0000_0000;
    localparam logic [16:0] DRL_START_RST = 17'h0_0000;
    localparam logic [9:0] DRL_LOFS_RST = 10'h000;
    localparam logic [9:0] DRL_DIM_RST = 10'h001;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode encodings.
    typedef enum logic [1:0]
    {
        DRL_ROT_0 = 2'b00,
        DRL_ROT_90 = 2'b01,
        DRL_ROT_180 = 2'b10,
        DRL_ROT_270 = 2'b11
    } drl_rot_t;

    typedef enum logic [2:0]
    {
        DRL_BPP_1 = 3'h0,
        DRL_BPP_2 = 3'h1,
        DRL_BPP_4 = 3'h2,
        DRL_BPP_8 = 3'h3,
        DRL_BPP_16 = 3'h4
    } drl_bpp_t;

    typedef enum logic [2:0]
    {
        DRL_ST_IDLE = 3'b000,
        DRL_ST_FETCH = 3'b001,
        DRL_ST_LOOK = 3'b011,
        DRL_ST_FORM = 3'b010,
        DRL_ST_SEND = 3'b110
    } drl_state_t;

    // Bits per pixel for a depth code; codes above 16 bpp fall back to 8 bpp.
    function automatic logic [5:0] drl_bpp_bits(input logic [2:0] code);
        logic [5:0] r;
        r = 6'h08;
        unique case (code)
            DRL_BPP_1: r = 6'h01;
            DRL_BPP_2: r = 6'h02;
            DRL_BPP_4: r = 6'h04;
            DRL_BPP_16: r = 6'h10;
            default: r = 6'h08;
        endcase
        return r;
    endfunction : drl_bpp_bits

endpackage : drl_pkg

/* File: design/drl_lut_mem.sv */
// Palette look-up table memory with one write port and a registered read port.
module drl_lut_mem
    import drl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [7:0] wr_idx,
    input wire logic [23:0] wr_data,
    input wire logic rd_en,
    input wire logic [7:0] rd_idx,
    output logic [23:0] rd_data_q
);

    logic [DRL_LUT_W-1:0] mem [DRL_LUT_DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // The array has no reset; software loads the palette before enabling refresh.
    always_ff @(posedge pclk)
    begin
        if (ce && wr_en)
        begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data_q <= 24'h00_0000;
        end
        else if (ce && rd_en)
        begin
            rd_data_q <= mem[rd_idx];
        end
    end

endmodule : drl_lut_mem

/* File: bench/drl_buffer_model.sv */
// Display buffer model that answers refresh fetches after a random stall.
module drl_buffer_model
    import drl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic mem_req,
    input wire logic [16:0] mem_addr,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;

    function automatic logic [31:0] word_at(input logic [16:0] a);
        return {a[7:0] ^ 8'ha5, a[15:8] + 8'h3c, a[7:0] * 8'h0d, ~a[7:0]};
    endfunction : word_at

    // Outside the ack cycle the bus shows the inverse word, so a late capture never matches.
    assign mem_rdata = mem_ack ? word_at(mem_addr) : ~word_at(mem_addr);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mem_ack <= 1'b0;
        else
            mem_ack <= mem_req && !mem_ack && !stall;
    end
endmodule : drl_buffer_model

/* File: bench/drl_refresh_monitor.sv */
// Port checker of the refresh block.
module drl_refresh_monitor
    import drl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic [16:0] mem_addr,
    input wire logic mem_ack,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic [7:0] pix_red_q,
    input wire logic [7:0] pix_green_q,
    input wire logic [7:0] pix_blue_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] ctrl_q;
    wire logic mapped = paddr inside {DRL_OFS_CTRL, DRL_OFS_START, DRL_OFS_LOFS, DRL_OFS_PANEL,
        DRL_OFS_STATUS, DRL_OFS_LUT_IDX, DRL_OFS_LUT_DATA};

    // Shadow of the control word, so pixel checks know the mode in force.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= DRL_CTRL_RST;
        else if (ce && psel && penable && pwrite && paddr == DRL_OFS_CTRL)
            ctrl_q <= pwdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence fetch_taken_s;
        mem_req && mem_ack && ce ##1 ce [*3];
    endsequence

    sequence pix_wait_s;
        pix_valid && !pix_ready;
    endsequence

    AST_PREADY_HIGH: assert property (psel && penable |-> pready)
        else $error("pready low in an access phase");
    AST_UNMAPPED_ERR: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");
    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("fetch request moved before ack");
    AST_PIX_HOLD: assert property (pix_wait_s |=> pix_valid && $stable({pix_red_q, pix_green_q, pix_blue_q}))
        else $error("pixel changed before handshake");
    AST_FETCH_TO_PIX: assert property (fetch_taken_s |-> pix_valid)
        else $error("pixel late after fetch");
    AST_MONO_GREEN: assert property (pix_valid && !ctrl_q[DRL_CTRL_COLOR_BIT] |->
        pix_red_q == pix_green_q && pix_blue_q == pix_green_q)
        else $error("mono pixel channels differ");
    AST_BYPASS_565: assert property (pix_valid && ctrl_q[4:0] == 5'h14 |->
        pix_red_q[2:0] == {3{ctrl_q[5]}} && pix_green_q[1:0] == {2{ctrl_q[5]}})
        else $error("565 pixel low bits wrong");
    AST_NO_DOUBLE: assert property (pix_valid && pix_ready && ce && ctrl_q[DRL_CTRL_ROT_LSB] |=> !pix_valid [*3])
        else $error("pixel repeated in quarter-turn mode");
    AST_RESET_QUIET: assert property ($rose(presetn) |-> !pix_valid && !mem_req)
        else $error("refresh active at reset release");
endmodule : drl_refresh_monitor

bind drl_refresh drl_refresh_monitor mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_req, .mem_addr, .mem_ack, .pix_valid, .pix_ready, .pix_red_q,
    .pix_green_q, .pix_blue_q);

/* File: bench/testbench.sv */
// Self-checking bench of the refresh block.
module testbench
    import drl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pix_ready = 1'b0, stall = 1'b0, er;
    logic [31:0] pwdata = 32'h0, lfsr = 32'hc07f, s = 32'hc07f, rd, prdata, mem_rdata;
    logic pready, pslverr, mem_req, mem_ack, pix_valid, pix_first_q, pix_eol_q;
    logic [16:0] mem_addr;
    logic [7:0] paddr = 8'h00, pix_red_q, pix_green_q, pix_blue_q;
    logic [25:0] exp_q[$];
    logic [23:0] lut[256];
    logic [31:0] cfgs[8] = '{32'h13, 32'h1_0023, 32'h2_0014, 32'h3_0004, 32'h50, 32'h1_0041, 32'h2_0072, 32'h3_0030};
    int err_count = 0, samples_checked = 0;

    always #50 pclk = ~pclk;

    drl_refresh dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .pix_valid, .pix_ready, .pix_red_q,
        .pix_green_q, .pix_blue_q, .pix_first_q, .pix_eol_q);
    drl_buffer_model mem (.pclk, .presetn, .stall, .mem_req, .mem_addr, .mem_rdata, .mem_ack);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pix(input logic [25:0] got, input logic [25:0] exp);
        chk_reg({6'h0, got}, {6'h0, exp});
    endtask : chk_pix

    task automatic test_done();
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        chk_reg(rd, exp);
    endtask : rd_chk

    function automatic logic [25:0] expect_pix(input int cur, input logic [31:0] cfg, input logic f, input logic l);
        logic [31:0] w;
        logic [15:0] v;
        logic [23:0] c;
        int b;
        b = 1 << cfg[2:0];
        w = mem.word_at(cur[21:5]);
        v = 16'((w >> (b == 16 ? cur[4] * 16 : cur[4:3] * 8 + 8 - cur[2:0] - b)) & ((1 << b) - 1));
        c = b == 16 ? {v[15:11], 3'h0, v[10:5], 2'h0, v[4:0], 3'h0} : lut[v[7:0]];
        if (!cfg[DRL_CTRL_COLOR_BIT])
            c = {3{c[15:8]}};
        if (cfg[DRL_CTRL_INVERT_BIT])
            c = ~c;
        return {f, l, c};
    endfunction : expect_pix

    task automatic run_frame(input logic [31:0] cfg);
        int b, dp, dl, n;
        logic [1:0] r;
        logic [25:0] e;
        b = 1 << cfg[2:0];
        r = cfg[17:16];
        dp = r == 2'b00 ? b : r == 2'b01 ? 64 : r == 2'b10 ? -b : -64;
        dl = r == 2'b00 ? 64 : r == 2'b01 ? -b : r == 2'b10 ? -64 : b;
        for (int j = 0; j < 2; j++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                e = expect_pix(160 + (r == 2'b01 || r == 2'b10 ? 32 - b : 0) + j * dl + i * dp, cfg, i + j == 0, i == 2);
                exp_q.push_back(e);
                if (cfg[DRL_CTRL_DOUBLE_BIT] && !r[0])
                    exp_q.push_back(e);
            end
        end
        wr(DRL_OFS_CTRL, cfg | 32'h0100_0000);
        n = 0;
        while (exp_q.size() > 0 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        chk_reg(32'(exp_q.size()), 32'h0);
        exp_q.delete();
        wr(DRL_OFS_CTRL, cfg);
        do
            apb(1'b0, DRL_OFS_STATUS, 32'h0, rd, er);
        while (rd[DRL_STAT_BUSY_BIT] !== 1'b0 && ++n < 6000);
        chk_reg({31'h0, rd[DRL_STAT_BUSY_BIT]}, 32'h0);
    endtask : run_frame

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        lfsr <= lfsr_next(lfsr);
        pix_ready <= lfsr[3] | lfsr[9];
        stall <= lfsr[5] & lfsr[6];
        if (presetn && ce && pix_valid === 1'b1 && pix_ready === 1'b1 && exp_q.size() > 0)
            chk_pix({pix_first_q, pix_eol_q, pix_red_q, pix_green_q, pix_blue_q}, exp_q.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(DRL_OFS_CTRL, DRL_CTRL_RST);
        rd_chk(DRL_OFS_PANEL, 32'h0001_0001);
        rd_chk(DRL_OFS_LUT_DATA, 32'h0);
        apb(1'b0, 8'h20, 32'h0, rd, er);
        chk_reg({31'h0, er}, 32'h1);
        ce <= 1'b0;
        wr(DRL_OFS_START, 32'h9);
        ce <= 1'b1;
        rd_chk(DRL_OFS_START, 32'h0);
        wr(DRL_OFS_START, 32'hfffe_0005);
        wr(DRL_OFS_LOFS, 32'hffff_fc02);
        wr(DRL_OFS_PANEL, 32'h0002_0003);
        rd_chk(DRL_OFS_START, 32'h5);
        rd_chk(DRL_OFS_LOFS, 32'h2);
        wr(DRL_OFS_LUT_IDX, 32'h0);
        for (int k = 0; k < 256; k++)
        begin
            s = lfsr_next(s);
            lut[k] = s[23:0];
            wr(DRL_OFS_LUT_DATA, {8'h0, s[23:0]});
        end
        rd_chk(DRL_OFS_LUT_IDX, 32'h0);
        foreach (cfgs[k])
            run_frame(cfgs[k]);
        test_done();
    end
endmodule : testbench
